// >>> logic/gtim_pkg.sv
/*
  Constants, register map and types for the general timer channel.
  Assumes one 250 MHz clock and a plain register port with 3-bit word index.
*/
// What this block does
// - Falling-edge counting: sample direction while event low, apply on event high.
// - Rising-edge counting: sample direction while event high, apply on event low.
// - One-shot with output enable clear releases the pin to plain I/O.
// - One-shot and PWM start triggers are synchronised to the count tick.
// - Width rewritten during high makes the next low the inverse of it.
// - 16-bit PWM starts pulses right after the synchronised trigger.
// - 8-bit PWM first drives low for one prescaled unit, then pulses.
// - Writing the value while counting clears start, except in PWM mode.
// - One-shot and PWM set the interrupt at the pulse falling edge.
package gtim_pkg;

  // ----------------------------------------------------------------
  // Register index map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] REG_MODE = 3'h0;
  localparam logic [2:0] REG_VALUE = 3'h1;
  localparam logic [2:0] REG_START = 3'h2;
  localparam logic [2:0] REG_PRESC = 3'h3;
  localparam logic [2:0] REG_IRQ_STAT = 3'h4;
  localparam logic [2:0] REG_IRQ_CLR = 3'h5;
  localparam logic [2:0] REG_IRQ_EN = 3'h6;

  // ----------------------------------------------------------------
  // Fields, reset values and modes
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int IRQ_W = 2;
  localparam int IRQ_PULSE_BIT = 0;
  localparam int IRQ_WRAP_BIT = 1;
  localparam int SYNC_W = 2;
  localparam int SYNC_EVENT_BIT = 0;
  localparam int SYNC_DIR_BIT = 1;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [7:0] PRESC_RESET = 8'h00;

  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_ONESHOT = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;

  // Mode register layout, bit 2 is the pulse output enable
  typedef struct packed {
    logic sw_dir;    // 7: direction when the pin is not used, 1 = up
    logic ext_trig;  // 6: trigger from event pin falling edge
    logic ext_dir;   // 5: direction taken from the shared pin
    logic pwm8;      // 4: 8-bit PWM variant
    logic rise_edge; // 3: count on rising edge instead of falling
    logic out_en;    // 2: pulse output drives the shared pin
    logic [1:0] mode;
  } gtim_mode_type;

  // Core sequencer states, Gray along idle-armed-lead-high-low
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_LEAD = 3'b011,
    ST_HIGH = 3'b010,
    ST_LOW = 3'b110
  } gtim_state_type;

endpackage

// >>> logic/gtim_top.sv
/*
  General 16-bit timer channel: timer, event counter, one-shot and PWM modes.
  Assumes a register master on the same clock and asynchronous pin inputs.
*/
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
module gtim_top (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [gtim_pkg::ADDR_W-1:0] i_addr,
  input wire logic [gtim_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [gtim_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_event_trigger_input_pin,
  input wire logic i_pulse_out_or_direction_pin,
  output logic o_pulse_out_or_direction_pin,
  output logic o_pulse_out_or_direction_pin_oe,
  output logic o_irq
);
  import gtim_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] prev_q;

  assign pins = {i_pulse_out_or_direction_pin, i_event_trigger_input_pin};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else if (i_ce) begin
          sync1_q[gi] <= pins[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  logic ev_lvl;
  logic ev_rise;
  logic ev_fall;
  assign ev_lvl = sync2_q[SYNC_EVENT_BIT];
  assign ev_rise = ev_lvl & ~prev_q[SYNC_EVENT_BIT];
  assign ev_fall = ~ev_lvl & prev_q[SYNC_EVENT_BIT];

  // ----------------------------------------------------------------
  // Registers and core state
  // ----------------------------------------------------------------
  gtim_mode_type mode_q, mode_d;
  logic [15:0] reload_q, reload_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0] presc_q, presc_d;
  logic [7:0] pre_q, pre_d;
  logic [7:0] sub_q, sub_d;
  logic start_q, start_d;
  logic pend_q, pend_d;
  logic dir_samp_q, dir_samp_d;
  logic dir_eff_q, dir_eff_d;
  logic out_q, out_d;
  logic oe_q, oe_d;
  logic irq_q, irq_d;
  logic [IRQ_W-1:0] stat_q, stat_d;
  logic [IRQ_W-1:0] en_q, en_d;
  logic [15:0] rdata_q, rdata_d;
  gtim_state_type st_q, st_d;

  logic wr_mode;
  logic wr_value;
  logic wr_start;
  logic tick;
  logic unit;
  logic pulse_mode;
  logic trig;
  logic [IRQ_W-1:0] set_ev;

  assign wr_mode = i_wr & (i_addr == REG_MODE);
  assign wr_value = i_wr & (i_addr == REG_VALUE);
  assign wr_start = i_wr & (i_addr == REG_START);
  assign pulse_mode = (mode_q.mode == MODE_ONESHOT) | (mode_q.mode == MODE_PWM);
  // Compare is not equality, so lowering the prescaler never waits for a wrap
  assign tick = (pre_q >= presc_q);
  // 8-bit PWM runs on units of (high byte + 1) ticks
  assign unit = mode_q.pwm8 ? (tick & (sub_q == reload_q[15:8])) : tick;
  // Trigger from event pin or from software setting the start flag
  assign trig = mode_q.ext_trig ? (ev_fall & start_q) : (wr_start & i_wdata[0] & ~start_q);

  // Register file next values
  always_comb begin
    mode_d = mode_q;
    reload_d = reload_q;
    presc_d = presc_q;
    en_d = en_q;
    if (wr_mode) begin
      mode_d = gtim_mode_type'(i_wdata[7:0]);
    end
    if (wr_value) begin
      reload_d = i_wdata;
    end
    if (i_wr & (i_addr == REG_PRESC)) begin
      presc_d = i_wdata[7:0];
    end
    if (i_wr & (i_addr == REG_IRQ_EN)) begin
      en_d = i_wdata[IRQ_W-1:0];
    end
  end

  // Read data, valid in the cycle after the strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        REG_MODE: rdata_d = {8'h00, mode_q};
        REG_VALUE: rdata_d = cnt_q;
        REG_START: rdata_d = {15'h0000, start_q};
        REG_PRESC: rdata_d = {8'h00, presc_q};
        REG_IRQ_STAT: rdata_d = {14'h0000, stat_q};
        REG_IRQ_EN: rdata_d = {14'h0000, en_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // Prescaler and 8-bit PWM unit divider
  always_comb begin
    pre_d = tick ? 8'h00 : 8'(pre_q + 8'h01);
    sub_d = sub_q;
    if (tick) begin
      sub_d = unit ? 8'h00 : 8'(sub_q + 8'h01);
    end
    if (st_q == ST_IDLE || st_q == ST_ARMED) begin
      sub_d = 8'h00;
    end
  end

  // Direction capture for event counting
  always_comb begin
    dir_samp_d = dir_samp_q;
    dir_eff_d = dir_eff_q;
    if (!mode_q.ext_dir) begin
      dir_eff_d = mode_q.sw_dir;
    end else if (!mode_q.rise_edge) begin
      // sample while low, apply on rise
      if (!ev_lvl) begin
        dir_samp_d = sync2_q[SYNC_DIR_BIT];
      end
      if (ev_rise) begin
        dir_eff_d = dir_samp_q;
      end
    end else begin
      // sample while high, apply on fall
      if (ev_lvl) begin
        dir_samp_d = sync2_q[SYNC_DIR_BIT];
      end
      if (ev_fall) begin
        dir_eff_d = dir_samp_q;
      end
    end
  end

  // Counter, start flag, pulse sequencer
  always_comb begin
    cnt_d = cnt_q;
    start_d = start_q;
    pend_d = pend_q;
    out_d = out_q;
    st_d = st_q;
    set_ev = '0;
    if (wr_start) begin
      start_d = i_wdata[0];
    end
    // trigger held until the next count tick
    if (trig) begin
      pend_d = 1'b1;
    end
    case (mode_q.mode)
      MODE_TIMER: begin
        if (start_q && tick) begin
          if (cnt_q == 16'h0000) begin
            cnt_d = reload_q;
            set_ev[IRQ_WRAP_BIT] = 1'b1;
          end else begin
            cnt_d = 16'(cnt_q - 16'h0001);
          end
        end
      end
      MODE_EVENT: begin
        if (start_q && (mode_q.rise_edge ? ev_rise : ev_fall)) begin
          if (dir_eff_q) begin
            cnt_d = (cnt_q == 16'hFFFF) ? reload_q : 16'(cnt_q + 16'h0001);
            set_ev[IRQ_WRAP_BIT] = (cnt_q == 16'hFFFF);
          end else begin
            cnt_d = (cnt_q == 16'h0000) ? reload_q : 16'(cnt_q - 16'h0001);
            set_ev[IRQ_WRAP_BIT] = (cnt_q == 16'h0000);
          end
        end
      end
      default: begin
        case (st_q)
          ST_IDLE: begin
            out_d = 1'b0;
            if (pend_q || trig) begin
              st_d = ST_ARMED;
            end
          end
          ST_ARMED: begin
            if (tick) begin
              pend_d = trig;
              if (mode_q.mode == MODE_PWM && mode_q.pwm8) begin
                // one low unit before the first pulse
                st_d = ST_LEAD;
                out_d = 1'b0;
              end else begin
                // pulse starts on the synchronised trigger
                st_d = ST_HIGH;
                out_d = 1'b1;
                cnt_d = mode_q.pwm8 ? {8'h00, reload_q[7:0]} : reload_q;
              end
            end
          end
          ST_LEAD: begin
            if (unit) begin
              st_d = ST_HIGH;
              out_d = 1'b1;
              cnt_d = {8'h00, reload_q[7:0]};
            end
          end
          ST_HIGH: begin
            if (unit) begin
              cnt_d = 16'(cnt_q - 16'h0001);
              if (cnt_q <= 16'h0001) begin
                out_d = 1'b0;
                set_ev[IRQ_PULSE_BIT] = 1'b1;
                if (mode_q.mode == MODE_PWM) begin
                  // low span is the inverse of the current value
                  st_d = ST_LOW;
                  cnt_d = mode_q.pwm8 ? {8'h00, ~reload_q[7:0]} : ~reload_q;
                end else begin
                  st_d = ST_IDLE;
                end
              end
            end
          end
          ST_LOW: begin
            if (unit) begin
              cnt_d = 16'(cnt_q - 16'h0001);
              if (cnt_q <= 16'h0001) begin
                st_d = ST_HIGH;
                out_d = 1'b1;
                cnt_d = mode_q.pwm8 ? {8'h00, reload_q[7:0]} : reload_q;
              end
            end
          end
          default: begin
            st_d = ST_IDLE;
            out_d = 1'b0;
          end
        endcase
      end
    endcase
    // value write stops counting outside PWM
    if (wr_value) begin
      if (mode_q.mode != MODE_PWM) begin
        start_d = 1'b0;
        cnt_d = i_wdata;
      end else if (!start_q) begin
        cnt_d = i_wdata;
      end
    end
    // Stopped or not a pulse mode: sequencer rests low
    if (!start_d || !pulse_mode) begin
      st_d = ST_IDLE;
      out_d = 1'b0;
      pend_d = 1'b0;
    end
  end

  // Sticky status, set wins over clear; output enable and interrupt
  always_comb begin
    stat_d = stat_q | set_ev;
    if (i_wr & (i_addr == REG_IRQ_CLR)) begin
      stat_d = (stat_q & ~i_wdata[IRQ_W-1:0]) | set_ev;
    end
    // pin released when output enable is clear
    oe_d = ((mode_d.mode == MODE_ONESHOT) | (mode_d.mode == MODE_PWM)) & mode_d.out_en;
    irq_d = |(stat_d & en_d);
  end

  // State registers
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      mode_q <= gtim_mode_type'(MODE_RESET);
      reload_q <= VALUE_RESET;
      cnt_q <= VALUE_RESET;
      presc_q <= PRESC_RESET;
      pre_q <= 8'h00;
      sub_q <= 8'h00;
      start_q <= 1'b0;
      pend_q <= 1'b0;
      dir_samp_q <= 1'b0;
      dir_eff_q <= 1'b0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      irq_q <= 1'b0;
      stat_q <= '0;
      en_q <= '0;
      rdata_q <= 16'h0000;
      st_q <= ST_IDLE;
    end else if (i_ce) begin
      mode_q <= mode_d;
      reload_q <= reload_d;
      cnt_q <= cnt_d;
      presc_q <= presc_d;
      pre_q <= pre_d;
      sub_q <= sub_d;
      start_q <= start_d;
      pend_q <= pend_d;
      dir_samp_q <= dir_samp_d;
      dir_eff_q <= dir_eff_d;
      out_q <= out_d;
      oe_q <= oe_d;
      irq_q <= irq_d;
      stat_q <= stat_d;
      en_q <= en_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pulse_out_or_direction_pin = out_q;
  assign o_pulse_out_or_direction_pin_oe = oe_q;
  assign o_irq = irq_q;

endmodule

// >>> tb/gtim_sva.sv
/*
  Port checker for the timer channel.
  Assumes a bind to gtim_top, with no strobes while i_ce is low.
*/
`timescale 1ns/100ps
module gtim_sva
  import gtim_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic i_event_trigger_input_pin,
  input wire logic i_pulse_out_or_direction_pin,
  input wire logic o_pulse_out_or_direction_pin,
  input wire logic o_pulse_out_or_direction_pin_oe,
  input wire logic o_irq
);
  logic [1:0] en_q;
  logic [1:0] en_d;
  wire logic oe = o_pulse_out_or_direction_pin_oe;
  wire logic po = o_pulse_out_or_direction_pin;
  wire logic wmode = i_wr && i_addr == REG_MODE;
  // Shadow of the interrupt enable register
  always_comb begin
    en_d = en_q;
    if (i_ce && i_wr && i_addr == REG_IRQ_EN) begin
      en_d = i_wdata[1:0];
    end
  end
  always_ff @(posedge i_mclk) begin
    en_q <= i_resetn ? en_d : 2'h0;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking dc @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  property p_rst_out;
    $rose(i_resetn) |-> o_rdata == 16'h0000 && !o_irq && !oe && !po;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
  property p_rd_idle;
    !i_rd |=> o_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
  property p_rd_en;
    i_rd && i_addr == REG_IRQ_EN |=> o_rdata == {14'h0000, en_q};
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable register read back wrong");
  property p_oe_on;
    wmode && i_wdata[2] && i_wdata[1] |=> ##1 oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pulse pin not driven");
  property p_oe_off;
    wmode && !i_wdata[2] |=> ##1 !oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pulse pin not released");
  property p_oe_cause;
    $changed(oe) |-> $past(wmode);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved without mode write");
  property p_irq_off;
    i_wr && i_addr == REG_IRQ_EN && i_wdata[1:0] == 2'h0 |=> ##1 !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt high while disabled");
  property p_fall_irq;
    $fell(po) && en_q[IRQ_PULSE_BIT] && !$past(i_wr) && !$past(i_wr, 2) |-> o_irq;
  endproperty
  a_fall_irq: assert property (p_fall_irq) else $error("no interrupt at pulse fall");
  c_fall: cover property ($fell(po));
  c_irq: cover property ($rose(o_irq));
  c_event: cover property ($fell(i_event_trigger_input_pin) && !i_pulse_out_or_direction_pin);
endmodule

// >>> tb/gtim_src_model.sv
/*
  Model of the event source and the direction input.
  Assumes the bench calls its tasks; each phase lasts HOLD clocks, 1 us at 4 ns.
*/
`timescale 1ns/100ps
module gtim_src_model #(
  parameter int HOLD = 250
) (
  input wire logic i_mclk,
  output logic o_event,
  output logic o_dir
);
  task automatic hold_phase();
    repeat (HOLD) @(posedge i_mclk);
  endtask
  // Park the event line at the level after the active edge
  task automatic park(input logic lvl);
    @(posedge i_mclk);
    o_event <= lvl;
    hold_phase();
  endtask
  // direction set in the level after the active edge
  task automatic pulse(input logic up);
    @(posedge i_mclk);
    o_dir <= up;
    hold_phase();
    o_event <= ~o_event;
    hold_phase();
    o_event <= ~o_event;
  endtask
  initial begin
    o_event = 1'b0;
    o_dir = 1'b1;
  end
endmodule

// >>> tb/testbench.sv
/*
  Self-checking bench for the timer channel.
  Assumes the package, gtim_top, the source model and the checker.
*/
`timescale 1ns/100ps
module testbench;
  import gtim_pkg::*;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic [ADDR_W-1:0] i_addr = 3'h0;
  logic [DATA_W-1:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic ce;
  logic [DATA_W-1:0] o_rdata;
  logic ev;
  logic src_dir;
  logic o_pulse;
  logic o_oe;
  logic o_irq;
  wire logic dir_pin = o_oe ? o_pulse : src_dir;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  int lag16;
  always #2 i_mclk = ~i_mclk;
  gtim_top gtim_top_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_event_trigger_input_pin(ev),
    .i_pulse_out_or_direction_pin(dir_pin), .o_pulse_out_or_direction_pin(o_pulse),
    .o_pulse_out_or_direction_pin_oe(o_oe), .o_irq(o_irq));
  gtim_src_model gtim_src_model_i (.i_mclk(i_mclk), .o_event(ev), .o_dir(src_dir));
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string what);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    check(what, o_rdata, exp);
  endtask
  // Count clocks until the pulse output reaches a level
  task automatic wait_out(input logic lvl, output int cnt);
    cnt = 0;
    #1;
    while (o_pulse !== lvl && cnt < 600) begin
      @(posedge i_mclk);
      #1;
      cnt++;
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    ce <= 1'b1;
    repeat (16) @(posedge i_mclk);
    i_resetn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), 16'h0000, "reset value");
    end
    wr(3'h7, 16'hFFFF);
    rd(3'h7, 16'h0000, "unmapped");
    wr(REG_PRESC, 16'h01FF);
    rd(REG_PRESC, 16'h00FF, "prescaler");
    wr(REG_IRQ_EN, 16'h0001);
    rd(REG_IRQ_EN, 16'h0001, "irq enable");
    $display("Test registers done");
    for (int p = 0; p < 4; p += 3) begin
      wr(REG_PRESC, 16'(p));
      wr(REG_VALUE, 16'h0002);
      wr(REG_MODE, 16'h0006);
      wr(REG_START, 16'h0001);
      wait_out(1'b1, n);
      check("oneshot lag", 16'(n <= p + 3), 16'h0001);
      check("pin driven", {15'h0000, o_oe}, 16'h0001);
      wait_out(1'b0, n);
      check("oneshot width", 16'(n), 16'(2 * (p + 1)));
      check("irq", {15'h0000, o_irq}, 16'h0001);
      rd(REG_IRQ_STAT, 16'h0001, "pulse status");
      wr(REG_IRQ_CLR, 16'h0003);
    end
    wr(REG_MODE, 16'h0002);
    @(posedge i_mclk);
    #1;
    check("pin released", {15'h0000, o_oe}, 16'h0000);
    $display("Test one-shot done");
    wr(REG_PRESC, 16'h0000);
    wr(REG_MODE, 16'h0000);
    wr(REG_VALUE, 16'h0100);
    wr(REG_START, 16'h0001);
    repeat (8) @(posedge i_mclk);
    wr(REG_VALUE, 16'h0050);
    repeat (8) @(posedge i_mclk);
    rd(REG_VALUE, 16'h0050, "stopped count");
    // Clock enable low must freeze the running timer
    wr(REG_START, 16'h0001);
    ce <= 1'b0;
    repeat (8) @(posedge i_mclk);
    ce <= 1'b1;
    rd(REG_VALUE, 16'h004F, "frozen count");
    wr(REG_MODE, 16'h0021);
    wr(REG_VALUE, 16'h0010);
    wr(REG_START, 16'h0001);
    repeat (3) gtim_src_model_i.pulse(1'b0);
    gtim_src_model_i.pulse(1'b1);
    repeat (6) @(posedge i_mclk);
    rd(REG_VALUE, 16'h000E, "falling count");
    gtim_src_model_i.park(1'b1);
    wr(REG_MODE, 16'h0029);
    wr(REG_VALUE, 16'h0010);
    wr(REG_START, 16'h0001);
    repeat (2) gtim_src_model_i.pulse(1'b1);
    gtim_src_model_i.pulse(1'b0);
    repeat (6) @(posedge i_mclk);
    rd(REG_VALUE, 16'h0011, "rising count");
    $display("Test counting done");
    wr(REG_START, 16'h0000);
    wr(REG_MODE, 16'h0007);
    wr(REG_VALUE, 16'h0003);
    wr(REG_START, 16'h0001);
    wait_out(1'b1, lag16);
    wait_out(1'b0, n);
    check("pwm16 high", 16'(n), 16'h0003);
    wr(REG_START, 16'h0000);
    wr(REG_VALUE, 16'h00FD);
    wr(REG_MODE, 16'h0017);
    wr(REG_START, 16'h0001);
    wait_out(1'b1, n);
    check("pwm8 lead", 16'(n), 16'(lag16 + 1));
    repeat (20) @(posedge i_mclk);
    wr(REG_VALUE, 16'h00FC);
    wait_out(1'b0, n);
    wait_out(1'b1, n);
    check("pwm8 low", 16'(n), 16'h0003);
    wr(REG_START, 16'h0000);
    // Masking the pending pulse status drops the interrupt
    wr(REG_IRQ_EN, 16'h0000);
    @(posedge i_mclk);
    #1;
    check("irq masked", {15'h0000, o_irq}, 16'h0000);
    $display("Test pwm done");
    tally_and_finish();
  end
endmodule

bind gtim_top gtim_sva gtim_sva_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_event_trigger_input_pin(i_event_trigger_input_pin),
  .i_pulse_out_or_direction_pin(i_pulse_out_or_direction_pin),
  .o_pulse_out_or_direction_pin(o_pulse_out_or_direction_pin),
  .o_pulse_out_or_direction_pin_oe(o_pulse_out_or_direction_pin_oe), .o_irq(o_irq));
